/* pkg/ctxs_pkg.sv */
// Purpose: Shared constants and types for the CAN transmit buffer scheduler.
// Assumes: At most fifteen message buffers, 16-bit register words.
// Notes:   Register offsets are word indices on the plain register port.
`default_nettype none
package ctxs_pkg;
  // ==========================================================================
  // Sizes
  localparam int NBUF   = 15;
  localparam int IDX_W  = 4;
  localparam int CODE_W = 4;
  localparam int RANK_W = 4;
  localparam int DATA_W = 16;
  localparam int ADDR_W = 5;
  // ==========================================================================
  // Buffer condition codes
  localparam logic [3:0] CODE_SEND_IDLE  = 4'h8;
  localparam logic [3:0] CODE_SINGLE     = 4'hC;
  localparam logic [3:0] CODE_THEN_AWAIT = 4'hE;
  localparam logic [3:0] CODE_AWAIT      = 4'hA;
  localparam logic [3:0] CODE_RX_ARMED   = 4'h2;
  localparam int         BUSY_BIT        = 0;
  localparam int         TX_BIT          = 3;
  // ==========================================================================
  // Buffer control word fields
  localparam int CW_CODE_LSB   = 0;
  localparam int CW_REMOTE_BIT = 4;
  localparam int CW_RANK_LSB   = 8;
  // ==========================================================================
  // Register map
  localparam logic [4:0] ADDR_CTRL_BASE    = 5'h00;
  localparam logic [4:0] ADDR_PAYLOAD_BASE = 5'h10;
  localparam logic [4:0] ADDR_STATUS       = 5'h1F;
  localparam int         ST_CUR_LSB        = 0;
  localparam int         ST_NEXT_LSB       = 4;
  localparam int         ST_CUR_VALID      = 8;
  localparam int         ST_NEXT_VALID     = 9;
  localparam int         ST_RECOVER        = 10;
  localparam logic [15:0] RESET_WORD       = 16'h0000;
  // ==========================================================================
  // Link phases
  typedef enum logic [1:0] {
    CTXS_IDLE,
    CTXS_SENDING,
    CTXS_RECOVER
  } ctxs_link_t;
endpackage : ctxs_pkg
`default_nettype wire

/* pkg/ctxs_sel_if.sv */
// Purpose: Carries candidate set and ranks to the selector and the winner back.
// Assumes: ctxs_pkg compiled first.
// Notes:   Purely combinational signals.
`default_nettype none
interface ctxs_sel_if #(
  parameter int NB = ctxs_pkg::NBUF
);
  import ctxs_pkg::*;
  logic [NB-1:0]     cand;
  logic [RANK_W-1:0] rank [NB];
  logic [IDX_W-1:0]  best;
  logic              found;
  modport sched (output cand, output rank, input best, input found);
  modport sel   (input cand, input rank, output best, output found);
endinterface : ctxs_sel_if
`default_nettype wire

/* logic/ctxs_rank_select.sv */
// Purpose: Picks the pending buffer with the lowest combined rank.
// Assumes: Buffer count fits the index width.
// Notes:   Strict less-than keeps the lower buffer number on a tie.
`default_nettype none
module ctxs_rank_select #(
  parameter int NB = ctxs_pkg::NBUF
) (
  ctxs_sel_if.sel sel
);
  import ctxs_pkg::*;
  // ==========================================================================
  // Combined rank search
  logic [7:0] best_rank;
  always_comb
  begin
    best_rank = 8'hFF;
    sel.best  = '0;
    sel.found = 1'b0;
    for (int i = 0; i < NB; i++)
    begin
      if (sel.cand[i] && (!sel.found ||
          {sel.rank[i], IDX_W'(i)} < best_rank)) // RL16 RL17
      begin
        best_rank = {sel.rank[i], IDX_W'(i)};
        sel.best  = IDX_W'(i);
        sel.found = 1'b1;
      end
    end
  end
endmodule : ctxs_rank_select
`default_nettype wire

/* logic/ctxs_scheduler.sv */
// What this block does
// RL1 - Code top bit set means transmit buffer.
// RL2 - Single-send shows busy on bus, then idle.
// RL3 - Failed send stays busy and retries; code clears busy when recovery ends and the buffer rearbitrates.
// RL4 - Sent remote frame arms buffer for receive.
// RL5 - Host sets masks to accept answer.
// RL6 - Matching remote frame triggers send, then await.
// RL7 - Code 1110 shows 1111, then awaits query.
// RL8 - Code 1010 only awaits, sends nothing.
// RL9 - Busy buffer accepts only code bits three-one.
// RL10 - Host writes to busy bit ignored.
// RL11 - From CRC start, schedule best pending buffer.
// RL12 - Better request displaces scheduled, which stays pending.
// RL13 - Host cancels by writing send-idle.
// RL14 - On failure wait recovery, then reselect.
// RL15 - Rearbitrate after each frame, back to back.
// RL16 - Combined rank: send rank then number.
// RL17 - Equal rank: lower buffer number wins.
// RL18 - Host idles buffer, then loads contents.
// RL19 - Writing single or then-await raises request.
// RL20 - Single-send goes busy only when scheduled.
// RL21 - Lowest code bit is the busy flag.
// RL22 - Event on data frame sent from single-send.
// RL23 - Busy codes equal written code plus busy.
//
// Purpose: Transmit buffer state and next-frame scheduling for a CAN engine.
// Assumes: Bit engine pulses crc_start, frame_start, tx_ok, tx_fail, recover.
// Notes:   Register reads answer one cycle after the read strobe.
`default_nettype none
module ctxs_scheduler #(
  parameter int NB = ctxs_pkg::NBUF
) (
  input  wire logic                        sys_clk_in,
  input  wire logic                        rst_in,
  input  wire logic [ctxs_pkg::ADDR_W-1:0] reg_addr_in,
  input  wire logic [ctxs_pkg::DATA_W-1:0] reg_wdata_in,
  input  wire logic                        reg_wr_in,
  input  wire logic                        reg_rd_in,
  output logic      [ctxs_pkg::DATA_W-1:0] reg_rdata_out,
  input  wire logic                        crc_start_in,
  input  wire logic                        frame_start_in,
  input  wire logic                        tx_ok_in,
  input  wire logic                        tx_fail_in,
  input  wire logic                        recover_in,
  input  wire logic                        rx_remote_in,
  input  wire logic [NB-1:0]               rx_hit_in,
  output logic                             tx_req_out,
  output logic      [ctxs_pkg::IDX_W-1:0]  tx_buf_out,
  output logic                             tx_remote_out,
  output logic      [ctxs_pkg::DATA_W-1:0] tx_payload_out,
  output logic                             done_event_out,
  output logic      [ctxs_pkg::IDX_W-1:0]  done_buf_out
);
  import ctxs_pkg::*;

  // ==========================================================================
  // Helpers
  function automatic logic is_tx_request(input logic [CODE_W-1:0] c);
    return (c[CODE_W-1:1] == CODE_SINGLE[CODE_W-1:1]) ||
           (c[CODE_W-1:1] == CODE_THEN_AWAIT[CODE_W-1:1]); // RL19
  endfunction : is_tx_request

  // ==========================================================================
  // State
  logic [CODE_W-1:0] code       [NB];
  logic [RANK_W-1:0] rank       [NB];
  logic [DATA_W-1:0] payload    [NB];
  logic [NB-1:0]     remote;
  logic [NB-1:0]     req;
  logic              cur_valid;
  logic [IDX_W-1:0]  cur_idx;
  logic              nxt_valid;
  logic [IDX_W-1:0]  nxt_idx;
  logic              crc_seen;
  ctxs_link_t        link;

  logic [CODE_W-1:0] next_code    [NB];
  logic [RANK_W-1:0] next_rank    [NB];
  logic [DATA_W-1:0] next_payload [NB];
  logic [NB-1:0]     next_remote;
  logic [NB-1:0]     next_req;
  logic              next_cur_valid;
  logic [IDX_W-1:0]  next_cur_idx;
  logic              next_nxt_valid;
  logic [IDX_W-1:0]  next_nxt_idx;
  logic              next_crc_seen;
  ctxs_link_t        next_link;
  logic [DATA_W-1:0] next_rdata;
  logic              next_done;
  logic [IDX_W-1:0]  next_done_buf;

  ctxs_sel_if #(.NB(NB)) sel_bus ();

  ctxs_rank_select #(.NB(NB)) u_select (
    .sel (sel_bus.sel)
  );

  // ==========================================================================
  // Candidates: pending requests not already on the bus
  always_comb
  begin
    for (int i = 0; i < NB; i++)
    begin
      sel_bus.cand[i] = req[i] && code[i][TX_BIT] && // RL1
        !(cur_valid && cur_idx == IDX_W'(i));
      sel_bus.rank[i] = rank[i];
    end
  end

  // ==========================================================================
  // Next-state logic
  always_comb
  begin
    logic [IDX_W-1:0]  w_idx;
    logic [CODE_W-1:0] w_code;
    logic              window;
    w_idx          = reg_addr_in[IDX_W-1:0];
    w_code         = '0;
    window         = 1'b0;
    next_code      = code;
    next_rank      = rank;
    next_payload   = payload;
    next_remote    = remote;
    next_req       = req;
    next_cur_valid = cur_valid;
    next_cur_idx   = cur_idx;
    next_nxt_valid = nxt_valid;
    next_nxt_idx   = nxt_idx;
    next_crc_seen  = crc_seen || crc_start_in;
    next_link      = link;
    next_done      = 1'b0;
    next_done_buf  = done_buf_out;
    next_rdata     = RESET_WORD;

    // Register reads; the answer stands only in the following cycle.
    if (reg_rd_in)
    begin
      if (reg_addr_in == ADDR_STATUS)
      begin
        next_rdata[ST_CUR_LSB +: IDX_W]  = cur_idx;
        next_rdata[ST_NEXT_LSB +: IDX_W] = nxt_idx;
        next_rdata[ST_CUR_VALID]         = cur_valid;
        next_rdata[ST_NEXT_VALID]        = nxt_valid;
        next_rdata[ST_RECOVER]           = (link == CTXS_RECOVER);
      end
      else if (int'(w_idx) < NB && reg_addr_in[4] == 1'b0)
      begin
        next_rdata[CW_CODE_LSB +: CODE_W] = code[w_idx];
        next_rdata[CW_REMOTE_BIT]         = remote[w_idx];
        next_rdata[CW_RANK_LSB +: RANK_W] = rank[w_idx];
      end
      else if (int'(w_idx) < NB)
      begin
        next_rdata = payload[w_idx];
      end
    end

    // Remote frame received: waiting buffers that matched start a send.
    if (rx_remote_in)
    begin
      for (int i = 0; i < NB; i++)
      begin
        if (rx_hit_in[i] && code[i] == CODE_AWAIT)
        begin
          next_code[i] = CODE_THEN_AWAIT; // RL6
          next_req[i]  = 1'b1;
        end
      end
    end

    // Frame outcome for the buffer on the bus.
    if (link == CTXS_SENDING && tx_ok_in)
    begin
      next_cur_valid        = 1'b0;
      next_link             = CTXS_IDLE; // RL15
      next_req[cur_idx]     = 1'b0;
      next_code[cur_idx][BUSY_BIT] = 1'b0;
      if (code[cur_idx] == (CODE_SINGLE | 4'h1))
      begin
        if (remote[cur_idx])
          next_code[cur_idx] = CODE_RX_ARMED; // RL4
        else
        begin
          next_code[cur_idx] = CODE_SEND_IDLE; // RL2
          next_done          = 1'b1; // RL22
          next_done_buf      = cur_idx;
        end
      end
      else if (code[cur_idx] == (CODE_THEN_AWAIT | 4'h1))
        next_code[cur_idx] = CODE_AWAIT; // RL7 RL6
    end
    else if (link == CTXS_SENDING && tx_fail_in)
      next_link = CTXS_RECOVER; // RL3 RL14
    else if (link == CTXS_RECOVER && recover_in)
    begin
      // The failed buffer rejoins the pool with its request still set.
      next_link                    = CTXS_IDLE; // RL14
      next_cur_valid               = 1'b0;
      next_code[cur_idx][BUSY_BIT] = 1'b0;
    end

    // Host write of a control word or payload word.
    if (reg_wr_in && int'(w_idx) < NB)
    begin
      if (reg_addr_in[4] == 1'b0)
      begin
        w_code = {reg_wdata_in[CW_CODE_LSB+1 +: CODE_W-1],
                  next_code[w_idx][BUSY_BIT]}; // RL10 RL21
        next_code[w_idx] = w_code; // RL9
        next_req[w_idx]  = is_tx_request(w_code); // RL19 RL8
        if (!code[w_idx][BUSY_BIT])
        begin
          next_remote[w_idx] = reg_wdata_in[CW_REMOTE_BIT];
          next_rank[w_idx]   = reg_wdata_in[CW_RANK_LSB +: RANK_W];
        end
        if (!is_tx_request(w_code) && nxt_valid && nxt_idx == w_idx)
        begin
          next_nxt_valid            = 1'b0; // RL13
          next_code[w_idx][BUSY_BIT] = 1'b0;
        end
      end
      else if (!code[w_idx][BUSY_BIT])
        next_payload[w_idx] = reg_wdata_in; // RL9
    end

    // Scheduling window: from CRC start, or whenever the link is free.
    window = (link == CTXS_IDLE) ||
             (link == CTXS_SENDING && (crc_seen || crc_start_in)); // RL11
    if (window && sel_bus.found &&
        !(reg_wr_in && reg_addr_in[4] == 1'b0 && w_idx == sel_bus.best) &&
        !(nxt_valid && nxt_idx == sel_bus.best) &&
        !(frame_start_in && nxt_valid)) // RL12
    begin
      if (nxt_valid)
        next_code[nxt_idx][BUSY_BIT] = 1'b0; // RL12
      next_code[sel_bus.best][BUSY_BIT] = 1'b1; // RL11 RL20 RL23
      next_nxt_valid = 1'b1;
      next_nxt_idx   = sel_bus.best;
    end

    // Next frame starts: the scheduled buffer goes onto the bus.
    if (frame_start_in && nxt_valid && next_nxt_valid &&
        next_link == CTXS_IDLE)
    begin
      next_cur_valid = 1'b1;
      next_cur_idx   = nxt_idx;
      next_nxt_valid = 1'b0;
      next_link      = CTXS_SENDING; // RL15
      next_crc_seen  = 1'b0;
    end
    else if (link != CTXS_SENDING)
      next_crc_seen = 1'b0;
  end

  // ==========================================================================
  // Registers
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
    begin
      for (int i = 0; i < NB; i++)
      begin
        code[i]    <= '0;
        rank[i]    <= '0;
        payload[i] <= '0;
      end
      remote         <= '0;
      req            <= '0;
      cur_valid      <= 1'b0;
      cur_idx        <= '0;
      nxt_valid      <= 1'b0;
      nxt_idx        <= '0;
      crc_seen       <= 1'b0;
      link           <= CTXS_IDLE;
      reg_rdata_out  <= '0;
      tx_req_out     <= 1'b0;
      tx_buf_out     <= '0;
      tx_remote_out  <= 1'b0;
      tx_payload_out <= '0;
      done_event_out <= 1'b0;
      done_buf_out   <= '0;
    end
    else
    begin
      code           <= next_code;
      rank           <= next_rank;
      payload        <= next_payload;
      remote         <= next_remote;
      req            <= next_req;
      cur_valid      <= next_cur_valid;
      cur_idx        <= next_cur_idx;
      nxt_valid      <= next_nxt_valid;
      nxt_idx        <= next_nxt_idx;
      crc_seen       <= next_crc_seen;
      link           <= next_link;
      reg_rdata_out  <= next_rdata;
      // Offer mirrors the scheduled buffer; it is safe to sample since the
      // contents are locked while the buffer is busy.
      tx_req_out     <= next_nxt_valid;
      tx_buf_out     <= next_nxt_idx;
      tx_remote_out  <= next_remote[next_nxt_idx];
      tx_payload_out <= next_payload[next_nxt_idx];
      done_event_out <= next_done;
      done_buf_out   <= next_done_buf;
    end
  end
endmodule : ctxs_scheduler
`default_nettype wire

/* bench/ctxs_scheduler_monitor.sv */
// Purpose: Concurrent checks on the transmit scheduler ports.
// Assumes: One clock, synchronous active-high reset.
// Notes:   Bound into every scheduler instance.
`default_nettype none
module ctxs_scheduler_monitor #(
  parameter int NB = ctxs_pkg::NBUF
) (
  input wire logic                       sys_clk_in,
  input wire logic                       rst_in,
  input wire logic                       reg_wr_in,
  input wire logic                       crc_start_in,
  input wire logic                       frame_start_in,
  input wire logic                       tx_ok_in,
  input wire logic                       tx_fail_in,
  input wire logic                       recover_in,
  input wire logic                       rx_remote_in,
  input wire logic                       tx_req_out,
  input wire logic [ctxs_pkg::IDX_W-1:0] tx_buf_out,
  input wire logic                       done_event_out,
  input wire logic [ctxs_pkg::IDX_W-1:0] done_buf_out
);
  timeunit 1ns;
  timeprecision 1ps;
  import ctxs_pkg::*;
  // ==========
  // Recovery tracking
  logic cause;
  logic rec;
  logic next_rec;
  assign cause = reg_wr_in | crc_start_in | recover_in | tx_ok_in
                 | rx_remote_in;
  always_comb next_rec = rst_in ? 1'b0 : tx_fail_in ? 1'b1
                         : recover_in ? 1'b0 : rec;
  always_ff @(posedge sys_clk_in) rec <= next_rec;
  // ==========
  // Checks
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  a_done_after_ok: assert property (done_event_out |-> $past(tx_ok_in))
    else $error("done event without a successful frame");
  a_done_one_pulse: assert property (done_event_out
    |=> !done_event_out)
    else $error("done event longer than one cycle");
  a_done_buf_hold: assert property (!done_event_out
    |-> $stable(done_buf_out))
    else $error("done buffer changed without an event");
  a_fail_no_done: assert property (tx_fail_in |=> !done_event_out [*2])
    else $error("done event after a failed frame");
  a_req_has_cause: assert property ($rose(tx_req_out) |-> $past(cause)
    || $past(cause, 2) || $past(cause, 3) || $past(cause, 4))
    else $error("request raised with no cause");
  a_no_sched_rec: assert property (rec |-> !$rose(tx_req_out))
    else $error("buffer scheduled during recovery");
  a_req_holds: assert property (tx_req_out && !frame_start_in
    && !reg_wr_in && !tx_fail_in |=> tx_req_out)
    else $error("scheduled request lost");
  a_buf_in_range: assert property (tx_req_out |-> tx_buf_out < NB)
    else $error("scheduled buffer out of range");
endmodule : ctxs_scheduler_monitor
bind ctxs_scheduler ctxs_scheduler_monitor #(.NB(NB)) mon (.sys_clk_in,
  .rst_in, .reg_wr_in, .crc_start_in, .frame_start_in, .tx_ok_in,
  .tx_fail_in, .recover_in, .rx_remote_in, .tx_req_out, .tx_buf_out,
  .done_event_out, .done_buf_out);
`default_nettype wire

/* bench/ctxs_can_peer.sv */
// Purpose: Bit engine seen by the scheduler; remote frames come from the bench.
// Assumes: One frame at a time, one-cycle pulses.
// Notes:   Starts a frame only while run_in is high.
`default_nettype none
module ctxs_can_peer (
  input  wire logic sys_clk_in,
  input  wire logic rst_in,
  input  wire logic run_in,
  input  wire logic fail_in,
  input  wire logic tx_req_in,
  output logic      frame_start_out,
  output logic      crc_start_out,
  output logic      tx_ok_out,
  output logic      tx_fail_out,
  output logic      recover_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] p;
  assign {frame_start_out, crc_start_out, tx_ok_out, tx_fail_out,
          recover_out} = p;
  task automatic pulse(input logic [4:0] v, input int gap);
    @(posedge sys_clk_in);
    p <= v;
    @(posedge sys_clk_in);
    p <= 5'h00;
    repeat (gap) @(posedge sys_clk_in);
  endtask : pulse
  // ==========
  // Frame sequencer
  initial
  begin
    p = 5'h00;
    forever
    begin
      @(posedge sys_clk_in);
      if (!rst_in && run_in && tx_req_in)
      begin
        pulse(5'h10, 6);
        pulse(5'h08, 6);
        if (fail_in)
        begin
          pulse(5'h02, 4);
          pulse(5'h01, 1);
        end
        else
          pulse(5'h04, 1);
      end
    end
  end
endmodule : ctxs_can_peer
`default_nettype wire

/* bench/ctxs_scheduler_test.sv */
// Purpose: Self-checking bench for the transmit buffer scheduler.
// Assumes: Peer model plays the bit engine; the bench drives the remote frames.
// Notes:   Control word is code[3:0], remote[4], rank[11:8].
`default_nettype none
module ctxs_scheduler_test;
  timeunit 1ns;
  timeprecision 1ps;
  import ctxs_pkg::*;
  logic              sys_clk_in, rst_in, reg_wr_in, reg_rd_in;
  logic              rx_remote_in, run, fail, tx_req_out;
  logic              frame_start_in, crc_start_in, tx_ok_in;
  logic              tx_fail_in, recover_in, tx_remote_out, done_event_out;
  logic [ADDR_W-1:0] reg_addr_in;
  logic [DATA_W-1:0] reg_wdata_in, reg_rdata_out, tx_payload_out, rv;
  logic [NBUF-1:0]   rx_hit_in;
  logic [IDX_W-1:0]  tx_buf_out, done_buf_out;
  logic [4:0]        ev;
  int                num_errors, checks;
  assign ev = {done_event_out, tx_fail_in, tx_ok_in, frame_start_in,
               tx_req_out};
  ctxs_scheduler #(.NB(NBUF)) uut (.sys_clk_in, .rst_in, .reg_addr_in,
    .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .crc_start_in,
    .frame_start_in, .tx_ok_in, .tx_fail_in, .recover_in, .rx_remote_in,
    .rx_hit_in, .tx_req_out, .tx_buf_out, .tx_remote_out, .tx_payload_out,
    .done_event_out, .done_buf_out);
  ctxs_can_peer peer (.sys_clk_in, .rst_in, .run_in(run), .fail_in(fail),
    .tx_req_in(tx_req_out), .frame_start_out(frame_start_in),
    .crc_start_out(crc_start_in), .tx_ok_out(tx_ok_in),
    .tx_fail_out(tx_fail_in), .recover_out(recover_in));
  // ==========
  // Helpers
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic acc(input logic w, input logic [4:0] a,
                     input logic [15:0] d);
    @(posedge sys_clk_in);
    reg_wr_in <= w;
    reg_rd_in <= !w;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge sys_clk_in);
    reg_wr_in <= 1'b0;
    reg_rd_in <= 1'b0;
    #1 rv = reg_rdata_out;
  endtask : acc
  task automatic rc(input logic [4:0] a, input logic [15:0] exp);
    acc(1'b0, a, 16'h0000);
    chk(rv, exp);
  endtask : rc
  // One edge passes first so a pulse already seen is not counted twice.
  task automatic wait_ev(input int w);
    int n;
    for (n = 0; n < 400; n++)
    begin
      @(posedge sys_clk_in);
      if (ev[w] === 1'b1)
        break;
    end
    chk({15'h0000, ev[w]}, 16'h0001);
  endtask : wait_ev
  task automatic stop_test;
    $display("errors=%0d checks=%0d", num_errors, checks);
    if (num_errors == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : stop_test
  // ==========
  // Scenarios
  task automatic t_single;
    run <= 1'b0;
    acc(1'b1, 5'h10, 16'h1234);
    acc(1'b1, 5'h00, 16'h000C);
    wait_ev(0);
    chk({12'h000, tx_buf_out}, 16'h0000);
    chk(tx_payload_out, 16'h1234);
    acc(1'b1, 5'h10, 16'hABCD);
    acc(1'b1, 5'h00, 16'h050C);
    rc(5'h10, 16'h1234);
    rc(5'h00, 16'h000D);
    run <= 1'b1;
    wait_ev(4);
    chk({12'h000, done_buf_out}, 16'h0000);
    run <= 1'b0;
    rc(5'h00, 16'h0008);
    acc(1'b1, 5'h00, 16'h0009);
    rc(5'h00, 16'h0008);
    acc(1'b1, 5'h00, 16'h000C);
    wait_ev(0);
    acc(1'b1, 5'h00, 16'h0008);
    repeat (3) @(posedge sys_clk_in);
    chk({15'h0000, tx_req_out}, 16'h0000);
    $display("t_single finished");
  endtask : t_single
  task automatic t_rank;
    acc(1'b1, 5'h03, 16'h010C);
    acc(1'b1, 5'h05, 16'h000C);
    acc(1'b1, 5'h02, 16'h000C);
    repeat (3) @(posedge sys_clk_in);
    chk({12'h000, tx_buf_out}, 16'h0002);
    rc(5'h03, 16'h010C);
    rc(5'h02, 16'h000D);
    run <= 1'b1;
    wait_ev(4);
    chk({12'h000, done_buf_out}, 16'h0002);
    wait_ev(4);
    chk({12'h000, done_buf_out}, 16'h0005);
    wait_ev(4);
    chk({12'h000, done_buf_out}, 16'h0003);
    $display("t_rank finished");
  endtask : t_rank
  task automatic t_fail;
    fail <= 1'b1;
    acc(1'b1, 5'h01, 16'h0008);
    acc(1'b1, 5'h01, 16'h000C);
    wait_ev(3);
    fail <= 1'b0;
    rc(5'h01, 16'h000D);
    rc(5'h1F, 16'h0511);
    wait_ev(4);
    chk({12'h000, done_buf_out}, 16'h0001);
    rc(5'h01, 16'h0008);
    $display("t_fail finished");
  endtask : t_fail
  task automatic t_remote;
    acc(1'b1, 5'h04, 16'h001C);
    wait_ev(0);
    chk({15'h0000, tx_remote_out}, 16'h0001);
    wait_ev(2);
    rc(5'h04, 16'h0012);
    acc(1'b1, 5'h06, 16'h000A);
    repeat (20) @(posedge sys_clk_in);
    chk({15'h0000, tx_req_out}, 16'h0000);
    @(posedge sys_clk_in);
    rx_hit_in <= 15'h0050;
    rx_remote_in <= 1'b1;
    @(posedge sys_clk_in);
    rx_remote_in <= 1'b0;
    wait_ev(1);
    rc(5'h06, 16'h000F);
    wait_ev(2);
    rc(5'h06, 16'h000A);
    rc(5'h04, 16'h0012);
    acc(1'b1, 5'h07, 16'h000E);
    wait_ev(1);
    rc(5'h07, 16'h000F);
    wait_ev(2);
    rc(5'h07, 16'h000A);
    $display("t_remote finished");
  endtask : t_remote
  // ==========
  // Main sequence
  initial
  begin
    sys_clk_in = 1'b0;
    forever #4 sys_clk_in = ~sys_clk_in;
  end
  initial
  begin
    #200000;
    num_errors++;
    stop_test;
  end
  initial
  begin
    {reg_wr_in, reg_rd_in, rx_remote_in, run, fail} = 5'h00;
    rst_in = 1'b1;
    reg_addr_in = 5'h00;
    reg_wdata_in = 16'h0000;
    rx_hit_in = 15'h0000;
    num_errors = 0;
    checks = 0;
    repeat (8) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    t_single;
    t_rank;
    t_fail;
    t_remote;
    stop_test;
  end
endmodule : ctxs_scheduler_test
`default_nettype wire
